// File: ptpcc_pkg.sv
// Constants for the PTP port capture configuration block
package ptpcc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFF_AUX_UPPER   = 12'h18C;
  localparam logic [11:0] OFF_AUX_LOWER   = 12'h190;
  localparam logic [11:0] OFF_TS_CONFIG   = 12'h194;
  localparam logic [11:0] OFF_CAP_STATUS  = 12'h198;

  // ****************************************
  // Configuration register fields
  // ****************************************
  localparam int          B_P1_MASTER     = 23;
  localparam int          B_P1_PRI_EN     = 22;
  localparam int          B_P1_ALT_A_EN   = 21;
  localparam int          B_P1_ALT_B_EN   = 20;
  localparam int          B_P1_ALT_C_EN   = 19;
  localparam int          B_P1_USER_EN    = 18;
  localparam int          B_P1_LOCK_RX    = 17;
  localparam int          B_P1_LOCK_TX    = 16;
  localparam int          B_P0_MASTER     = 15;
  localparam int          B_P0_PRI_EN     = 14;
  localparam logic [31:0] CFG_RESET       = 32'h0043_4000;
  localparam logic [31:0] CFG_WR_MASK     = 32'h00FF_C000;
  localparam logic [31:0] AUX_LOWER_RESET = 32'h0000_0000;
  localparam logic [15:0] AUX_UPPER_RESET = 16'h0000;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int          ST_HELD_LSB     = 0;
  localparam int          ST_CAPT_LSB     = 4;

  // ****************************************
  // PTP destination addresses and messages
  // ****************************************
  localparam logic [47:0] ADDR_PRIMARY    = 48'h0100_5E00_0181;
  localparam logic [47:0] ADDR_ALT_A      = 48'h0100_5E00_0182;
  localparam logic [47:0] ADDR_ALT_B      = 48'h0100_5E00_0183;
  localparam logic [47:0] ADDR_ALT_C      = 48'h0100_5E00_0184;
  localparam logic [3:0]  MSG_SYNC        = 4'h0;
  localparam logic [3:0]  MSG_DELAY_REQ   = 4'h1;

  // Channel index: port * 2 + direction (0 transmit, 1 receive)
  localparam int          NCH             = 4;

endpackage : ptpcc_pkg

// File: ptpcc_top.sv
// PTP timestamp capture configuration and frame qualification, ports 1 and 0
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns

module ptpcc_top
  import ptpcc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Port 1 transmit frame
  input  wire logic              p1_tx_valid,
  input  wire logic [47:0]       p1_tx_dest,
  input  wire logic [3:0]        p1_tx_msg,
  input  wire logic              p1_tx_pending,
  // Port 1 receive frame
  input  wire logic              p1_rx_valid,
  input  wire logic [47:0]       p1_rx_dest,
  input  wire logic [3:0]        p1_rx_msg,
  input  wire logic              p1_rx_pending,
  // Port 0 traffic entering the switch fabric
  input  wire logic              p0_to_fabric_valid,
  input  wire logic [47:0]       p0_to_fabric_dest,
  input  wire logic [3:0]        p0_to_fabric_msg,
  // Port 0 traffic leaving the switch fabric
  input  wire logic              p0_from_fabric_valid,
  input  wire logic [47:0]       p0_from_fabric_dest,
  input  wire logic [3:0]        p0_from_fabric_msg,
  // Capture strobes, index port*2+dir, dir 0 transmit, 1 receive
  output logic      [NCH-1:0]    cap_store,
  output logic      [NCH-1:0]    cap_held
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0]     cfg;
    logic [15:0]     aux_upper;
    logic [31:0]     aux_lower;
    logic [31:0]     rdata;
    logic [NCH-1:0]  store;
    logic [NCH-1:0]  held;
    logic [NCH-1:0]  held_sticky;
    logic [NCH-1:0]  capt_sticky;
  } ptpcc_state_s;

  ptpcc_state_s st;
  ptpcc_state_s next_st;

  // ****************************************
  // Channel gathering
  // ****************************************
  logic [NCH-1:0]       ch_valid;
  logic [NCH-1:0][47:0] ch_dest;
  logic [NCH-1:0][3:0]  ch_msg;
  logic [NCH-1:0]       ch_pending;
  logic [NCH-1:0]       ch_master;
  logic [NCH-1:0]       ch_lock;
  logic [NCH-1:0][4:0]  ch_addr_en;
  logic [NCH-1:0]       ch_addr_hit;
  logic [NCH-1:0]       ch_msg_hit;
  logic [NCH-1:0]       ch_qualify;
  logic [47:0]          aux_addr;

  assign aux_addr = {st.aux_upper, st.aux_lower};

  // Port 0 directions are seen from the port side
  assign ch_valid[0] = p0_to_fabric_valid;
  assign ch_dest[0]  = p0_to_fabric_dest;
  assign ch_msg[0]   = p0_to_fabric_msg;
  assign ch_valid[1] = p0_from_fabric_valid;
  assign ch_dest[1]  = p0_from_fabric_dest;
  assign ch_msg[1]   = p0_from_fabric_msg;
  assign ch_valid[2] = p1_tx_valid;
  assign ch_dest[2]  = p1_tx_dest;
  assign ch_msg[2]   = p1_tx_msg;
  assign ch_valid[3] = p1_rx_valid;
  assign ch_dest[3]  = p1_rx_dest;
  assign ch_msg[3]   = p1_rx_msg;

  // Port 0 locks are not held here; its captures always overwrite
  assign ch_pending = {p1_rx_pending, p1_tx_pending, 1'b0, 1'b0};
  assign ch_lock    = {st.cfg[B_P1_LOCK_RX], st.cfg[B_P1_LOCK_TX], 1'b0, 1'b0};

  assign ch_master[0] = st.cfg[B_P0_MASTER];
  assign ch_master[1] = st.cfg[B_P0_MASTER];
  assign ch_master[2] = st.cfg[B_P1_MASTER];
  assign ch_master[3] = st.cfg[B_P1_MASTER];

  // Enables ordered {user, alt_c, alt_b, alt_a, primary}
  assign ch_addr_en[0] = {4'h0, st.cfg[B_P0_PRI_EN]};
  assign ch_addr_en[1] = {4'h0, st.cfg[B_P0_PRI_EN]};
  assign ch_addr_en[2] = st.cfg[B_P1_PRI_EN:B_P1_USER_EN] == 5'h00 ? 5'h00 :
                         {st.cfg[B_P1_USER_EN], st.cfg[B_P1_ALT_C_EN],
                          st.cfg[B_P1_ALT_B_EN], st.cfg[B_P1_ALT_A_EN],
                          st.cfg[B_P1_PRI_EN]};
  assign ch_addr_en[3] = ch_addr_en[2];

  // ****************************************
  // Per-channel qualification
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [4:0] hit;
      assign hit[0] = ch_addr_en[g][0] && (ch_dest[g] == ADDR_PRIMARY);
      assign hit[1] = ch_addr_en[g][1] && (ch_dest[g] == ADDR_ALT_A);
      assign hit[2] = ch_addr_en[g][2] && (ch_dest[g] == ADDR_ALT_B);
      assign hit[3] = ch_addr_en[g][3] && (ch_dest[g] == ADDR_ALT_C);
      assign hit[4] = ch_addr_en[g][4] && (ch_dest[g] == aux_addr);
      assign ch_addr_hit[g] = |hit;
      // Even index transmits, odd index receives
      assign ch_msg_hit[g] = ((g % 2) == 0) ?
        (ch_msg[g] == (ch_master[g] ? MSG_SYNC : MSG_DELAY_REQ)) :
        (ch_msg[g] == (ch_master[g] ? MSG_DELAY_REQ : MSG_SYNC));
      assign ch_qualify[g] = ch_valid[g] && ch_addr_hit[g] && ch_msg_hit[g];
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  logic [NCH-1:0] lock_block;
  logic [NCH-1:0] store_now;
  logic [NCH-1:0] held_clr;
  logic [NCH-1:0] capt_clr;

  always_comb begin
    next_st    = st;
    lock_block = ch_lock & ch_pending;
    store_now  = ch_qualify & ~lock_block;
    held_clr   = '0;
    capt_clr   = '0;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_TS_CONFIG:  next_st.cfg       = reg_wdata & CFG_WR_MASK;
        OFF_AUX_UPPER:  next_st.aux_upper = reg_wdata[15:0];
        OFF_AUX_LOWER:  next_st.aux_lower = reg_wdata;
        OFF_CAP_STATUS: begin
          held_clr = reg_wdata[ST_HELD_LSB +: NCH];
          capt_clr = reg_wdata[ST_CAPT_LSB +: NCH];
        end
        default: ;
      endcase
    end

    // Capture strobes and sticky flags; a new event beats a clear
    next_st.store       = store_now;
    next_st.held        = ch_qualify & lock_block;
    next_st.held_sticky = (st.held_sticky & ~held_clr) | next_st.held;
    next_st.capt_sticky = (st.capt_sticky & ~capt_clr) | store_now;

    // Register reads, data stand one cycle later only
    next_st.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_TS_CONFIG:  next_st.rdata = st.cfg;
        OFF_AUX_UPPER:  next_st.rdata = {16'h0000, st.aux_upper};
        OFF_AUX_LOWER:  next_st.rdata = st.aux_lower;
        OFF_CAP_STATUS: begin
          next_st.rdata[ST_HELD_LSB +: NCH] = st.held_sticky;
          next_st.rdata[ST_CAPT_LSB +: NCH] = st.capt_sticky;
        end
        default:        next_st.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st             <= '0;
      st.cfg         <= CFG_RESET;
      st.aux_upper   <= AUX_UPPER_RESET;
      st.aux_lower   <= AUX_LOWER_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = st.rdata;
  assign cap_store = st.store;
  assign cap_held  = st.held;

endmodule : ptpcc_top

// File: ptpcc_sva.sv
// Checker for the PTP capture configuration block
`timescale 1ns/1ns
module ptpcc_sva
  import ptpcc_pkg::*;
(
  // Clock, reset and register port
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // Frames and capture strobes
  input wire logic              p1_rx_valid,
  input wire logic [47:0]       p1_rx_dest,
  input wire logic [3:0]        p1_rx_msg,
  input wire logic              p1_rx_pending,
  input wire logic              p0_to_fabric_valid,
  input wire logic [3:0]        p0_to_fabric_msg,
  input wire logic              p0_from_fabric_valid,
  input wire logic [47:0]       p0_from_fabric_dest,
  input wire logic [NCH-1:0]    cap_store,
  input wire logic [NCH-1:0]    cap_held
);
  logic [31:0] cfg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Mirror of the configuration register
  always_ff @(posedge clk) begin
    if (rst) cfg <= CFG_RESET;
    else if (reg_wr && reg_addr == OFF_TS_CONFIG) cfg <= reg_wdata & CFG_WR_MASK;
  end
  sequence rx_ok;
    p1_rx_valid && !p1_rx_pending && p1_rx_dest == ADDR_PRIMARY && cfg[B_P1_PRI_EN]
      && p1_rx_msg == (cfg[B_P1_MASTER] ? MSG_DELAY_REQ : MSG_SYNC);
  endsequence
  chk_rd_idle:
    assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data not idle");
  chk_cfg_read:
    assert property (reg_rd && reg_addr == OFF_TS_CONFIG |=> reg_rdata == $past(cfg))
    else $error("config readback wrong");
  chk_unmapped_read:
    assert property (reg_rd && reg_addr == 12'h000 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rx_lock:
    assert property (p1_rx_valid && p1_rx_pending && cfg[B_P1_LOCK_RX] |=> !cap_store[3])
    else $error("locked receive capture stored");
  chk_rx_walk:
    assert property (rx_ok |=> cap_store[3] && !cap_held[3]) else $error("rx capture lost");
  chk_rx_quiet:
    assert property (!p1_rx_valid |=> !cap_store[3] && !cap_held[3])
    else $error("rx strobe without frame");
  chk_p0_msg:
    assert property (p0_to_fabric_valid && p0_to_fabric_msg !=
      (cfg[B_P0_MASTER] ? MSG_SYNC : MSG_DELAY_REQ) |=> !cap_store[0])
    else $error("port 0 wrong message stored");
  chk_p0_addr:
    assert property (p0_from_fabric_valid && p0_from_fabric_dest != ADDR_PRIMARY
      |=> !cap_store[1]) else $error("port 0 foreign address stored");
endmodule : ptpcc_sva

bind ptpcc_top ptpcc_sva u_sva (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .p1_rx_valid, .p1_rx_dest, .p1_rx_msg, .p1_rx_pending, .p0_to_fabric_valid,
  .p0_to_fabric_msg, .p0_from_fabric_valid, .p0_from_fabric_dest, .cap_store, .cap_held);

// File: ptpcc_far.sv
// Frame source standing for the ports and the switch fabric
`timescale 1ns/1ns
module ptpcc_far
  import ptpcc_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Frame channels, indexed like the capture strobes
  output logic [NCH-1:0]       v,
  output logic [NCH-1:0][47:0] d,
  output logic [NCH-1:0][3:0]  m,
  output logic [1:0]           pd
);
  initial begin
    v  = '0;
    d  = '0;
    m  = '0;
    pd = '0;
  end
  // Released lines show the inverse of the last frame
  task send(input int c, input logic [47:0] a, input logic [3:0] t, input logic p);
    @(posedge clk);
    v[c] <= 1'b1;
    d[c] <= a;
    m[c] <= t;
    pd   <= {p, p};
    @(posedge clk);
    v[c] <= 1'b0;
    d[c] <= ~a;
    m[c] <= ~t;
  endtask : send
endmodule : ptpcc_far

// File: testbench.sv
// Self-checking bench for the PTP capture configuration block
`timescale 1ns/1ns
module testbench
  import ptpcc_pkg::*;
;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [ADDR_W-1:0]    reg_addr = '0;
  logic [31:0]          reg_wdata = '0;
  logic [31:0]          reg_rdata, cfg, aux_lo, r;
  logic [15:0]          aux_hi;
  logic [47:0]          a;
  logic [NCH-1:0]       v, cs, ch;
  logic [NCH-1:0][47:0] d;
  logic [NCH-1:0][3:0]  m;
  logic [1:0]           pd;
  logic [47:0]          dq[$];
  int                   miscompares = 0, compares = 0, seed = 76912, k;

  always #20 clk = ~clk;

  ptpcc_far u_far (.clk(clk), .v(v), .d(d), .m(m), .pd(pd));
  ptpcc_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p1_tx_valid(v[2]),
    .p1_tx_dest(d[2]), .p1_tx_msg(m[2]), .p1_tx_pending(pd[0]), .p1_rx_valid(v[3]),
    .p1_rx_dest(d[3]), .p1_rx_msg(m[3]), .p1_rx_pending(pd[1]),
    .p0_to_fabric_valid(v[0]), .p0_to_fabric_dest(d[0]), .p0_to_fabric_msg(m[0]),
    .p0_from_fabric_valid(v[1]), .p0_from_fabric_dest(d[1]), .p0_from_fabric_msg(m[1]),
    .cap_store(cs), .cap_held(ch));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] w);
    @(posedge clk);
    reg_addr  <= ad;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    if (ad == OFF_TS_CONFIG) cfg = w & CFG_WR_MASK;
    if (ad == OFF_AUX_LOWER) aux_lo = w;
    if (ad == OFF_AUX_UPPER) aux_hi = w[15:0];
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, e, "read");
  endtask : rd

  // Expected strobes: bits 3:0 stored, bits 7:4 held
  function automatic logic [31:0] want(input int c, input logic [47:0] ad,
                                       input logic [3:0] t, input logic p);
    logic        rx, hit, lk;
    logic [31:0] e;
    rx  = c[0];
    lk  = c > 1 && p && cfg[rx ? B_P1_LOCK_RX : B_P1_LOCK_TX];
    hit = (ad == ADDR_PRIMARY && cfg[c > 1 ? B_P1_PRI_EN : B_P0_PRI_EN]) || (c > 1 && (
      (ad == ADDR_ALT_A && cfg[B_P1_ALT_A_EN]) || (ad == ADDR_ALT_B && cfg[B_P1_ALT_B_EN]) ||
      (ad == ADDR_ALT_C && cfg[B_P1_ALT_C_EN]) ||
      (ad == {aux_hi, aux_lo} && cfg[B_P1_USER_EN])));
    hit = hit && t == ((cfg[c > 1 ? B_P1_MASTER : B_P0_MASTER] ^ rx) ? MSG_SYNC : MSG_DELAY_REQ);
    e = '0;
    e[lk ? c + 4 : c] = hit;
    return e;
  endfunction : want

  task automatic frame(input int c, input logic [47:0] ad, input logic [3:0] t, input logic p);
    u_far.send(c, ad, t, p);
    #1 check(32'({ch, cs}), want(c, ad, t, p), "capture");
  endtask : frame

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  initial begin
    cfg    = 32'h0043_4000;
    aux_lo = '0;
    aux_hi = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wr(12'h000, 32'hFFFF_FFFF);
    rd(OFF_TS_CONFIG, 32'h0043_4000);
    rd(OFF_AUX_UPPER, 32'h0);
    rd(OFF_AUX_LOWER, 32'h0);
    rd(12'h000, 32'h0);
    $display("test reset values done");
    frame(3, ADDR_PRIMARY, MSG_SYNC, 1'b0);
    frame(3, ADDR_PRIMARY, MSG_SYNC, 1'b1);
    frame(2, ADDR_PRIMARY, MSG_DELAY_REQ, 1'b1);
    frame(1, ADDR_PRIMARY, MSG_SYNC, 1'b1);
    rd(OFF_CAP_STATUS, 32'h0000_00AC);
    wr(OFF_CAP_STATUS, 32'h0000_00FF);
    rd(OFF_CAP_STATUS, 32'h0);
    $display("test walk done");
    wr(OFF_AUX_UPPER, $random(seed));
    wr(OFF_AUX_LOWER, $random(seed));
    rd(OFF_AUX_UPPER, {16'h0, aux_hi});
    rd(OFF_AUX_LOWER, aux_lo);
    $display("test aux address done");
    dq = {ADDR_PRIMARY, ADDR_ALT_A, ADDR_ALT_B, ADDR_ALT_C};
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      if (i % 8 == 0) begin
        wr(OFF_TS_CONFIG, $random(seed));
        rd(OFF_TS_CONFIG, cfg);
      end
      k = int'(r[10:8]) % 6;
      a = k < 4 ? dq[k] : (k == 4 ? {aux_hi, aux_lo} : {r, r[15:0]});
      frame(int'(r[1:0]), a, r[4:3] == 2'b11 ? 4'h2 : {3'h0, r[2]}, r[5]);
    end
    $display("test random frames done");
    summarize();
  end
endmodule : testbench
